// File: src/uaf_top.sv
// Purpose: serial element with 16-entry FIFOs and automatic RTS/CTS flow
// Assumes: register port on i_clock, serial pins asynchronous
// Notes: receiver samples on the internal 16x tick
`timescale 1ns/1ps
`include "uaf_map.svh"

// Summary of operation
// - With auto-CTS, no byte starts unless CTS is active.
// - Auto-RTS levels 1/4/8: RTS released when fill reaches trigger.
// - After release the sender may finish one byte; receiver keeps it.
// - Levels 1/4/8: RTS returns only once receive FIFO is empty.
// - Level 14: release RTS at first data bit of sixteenth byte.
// - Level 14: RTS returns once the FIFO has room again.
// - One free slot suffices only when no byte is arriving.
// - With receive FIFO full, the first data read returns RTS.
// - Auto-CTS: CTS is sampled before each new byte.
// - CTS dropped mid-byte: current byte finishes, next is held.
// - CTS held active: bytes leave back to back.
// - CTS active again: queued bytes resume.
// - Under autoflow, CTS changes raise no host event.
// - Without auto-CTS, transmitter ignores CTS.
// - Autoflow enable plus RTS bit give full auto RTS and CTS.
// - Autoflow enable with RTS bit clear gives auto-CTS only.
// - Receive trigger levels 1, 4, 8 and 14 bytes.
// - Sixteen-entry FIFOs; receive entries hold three error bits.
// - Autoflow only in FIFO mode; reset gives character mode.
// - 16-bit divisor 1 to 65535 makes the 16x tick.
// - Character length 5, 6, 7 or 8 data bits.
// - 16x tick is driven out on a pin.
module uaf_top #(
	parameter int DEPTH = `UAF_FIFO_DEPTH
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [7:0] o_rdata,
	input wire logic i_serial_input_line,
	output logic o_serial_output,
	input wire logic i_cts_n,
	output logic o_rts_n,
	output logic o_baud_clock_out,
	output logic o_transmit_dma_request,
	output logic o_receive_dma_request
);
	localparam int CW = $clog2(DEPTH) + 1;
	logic [7:0] lcr_reg;
	logic [7:0] fcr_reg;
	logic [7:0] mcr_reg;
	logic [15:0] div_reg;
	logic [15:0] baud_cnt_reg;
	logic baud_out_reg;
	logic [7:0] rdata_reg;
	logic cts_meta_reg, cts_sync_reg, cts_prev_reg, delta_cts_reg;
	logic sin_meta_reg, sin_sync_reg;
	logic overrun_reg, hold_reg, block14_reg;
	uaf_pkg::uaf_tx_state_e tx_state_reg;
	uaf_pkg::uaf_rx_state_e rx_state_reg;
	logic [3:0] tx_tick_reg, rx_tick_reg;
	logic [2:0] tx_bit_reg, rx_bit_reg;
	logic [7:0] tx_shift_reg, rx_shift_reg;
	logic tx_par_reg, tx_out_reg, rx_par_reg, rx_perr_reg;
	logic fifo_en, auto_cts, auto_rts, lvl14, tick, cts_active;
	logic [15:0] div_eff;
	logic [2:0] last_bit;
	logic [CW-1:0] limit, trig_val, rx_count, tx_count;
	logic tx_valid, tx_ready, tx_push, tx_pop, tx_load, tx_bit_end, tx_clear;
	logic rx_valid, rx_ready, rx_push, rx_pop, rx_mid, rx_first_bit, rx_clear;
	logic [7:0] tx_head;
	uaf_pkg::uaf_rx_entry_s rx_entry, rx_head;
	logic fcr_wr, rts_release;

	// ****************************************
	// Control decode
	// ****************************************
	assign fifo_en = fcr_reg[`UAF_FCR_EN];
	assign auto_cts = fifo_en && mcr_reg[`UAF_MCR_AFE];
	assign auto_rts = auto_cts && mcr_reg[`UAF_MCR_RTS];
	assign lvl14 = fcr_reg[7:6] == 2'h3;
	assign limit = fifo_en ? CW'(DEPTH) : CW'(1);
	assign last_bit = `UAF_DATA_BIT_BASE + {1'b0, lcr_reg[1:0]};
	assign fcr_wr = i_write && i_addr == `UAF_ADDR_FIFO_CTRL;
	assign tx_clear = fcr_wr && (i_wdata[`UAF_FCR_TX_CLR] || i_wdata[`UAF_FCR_EN] != fifo_en);
	assign rx_clear = fcr_wr && (i_wdata[`UAF_FCR_RX_CLR] || i_wdata[`UAF_FCR_EN] != fifo_en);

	// Receive trigger level
	always_comb begin
		case (fcr_reg[7:6])
			2'h0: trig_val = CW'(`UAF_TRIG_1);
			2'h1: trig_val = CW'(`UAF_TRIG_4);
			2'h2: trig_val = CW'(`UAF_TRIG_8);
			default: trig_val = CW'(`UAF_TRIG_14);
		endcase
	end

	// Software-written control registers
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			lcr_reg <= `UAF_LCR_RST;
			fcr_reg <= `UAF_FCR_RST;
			mcr_reg <= `UAF_MCR_RST;
			div_reg <= `UAF_DIV_RST;
		end else if (i_write) begin
			case (i_addr)
				`UAF_ADDR_LINE_CTRL: lcr_reg <= i_wdata;
				`UAF_ADDR_FIFO_CTRL: fcr_reg <= i_wdata & `UAF_FCR_KEEP;
				`UAF_ADDR_MODEM_CTRL: mcr_reg <= i_wdata;
				`UAF_ADDR_DIV_LO: div_reg[7:0] <= i_wdata;
				`UAF_ADDR_DIV_HI: div_reg[15:8] <= i_wdata;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Baud generator
	// ****************************************
	assign div_eff = (div_reg == 16'h0000) ? 16'h0001 : div_reg;
	assign tick = baud_cnt_reg >= div_eff - 16'h0001;
	assign o_baud_clock_out = baud_out_reg;

	// Divider and 16x pin
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			baud_cnt_reg <= 16'h0000;
			baud_out_reg <= 1'b0;
		end else begin
			baud_cnt_reg <= tick ? 16'h0000 : baud_cnt_reg + 16'h0001;
			baud_out_reg <= tick;
		end
	end

	// ****************************************
	// Pin synchronisers and CTS change flag
	// ****************************************
	assign cts_active = !cts_sync_reg;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			cts_meta_reg <= 1'b1;
			cts_sync_reg <= 1'b1;
			cts_prev_reg <= 1'b1;
			sin_meta_reg <= 1'b1;
			sin_sync_reg <= 1'b1;
		end else begin
			cts_meta_reg <= i_cts_n;
			cts_sync_reg <= cts_meta_reg;
			cts_prev_reg <= cts_sync_reg;
			sin_meta_reg <= i_serial_input_line;
			sin_sync_reg <= sin_meta_reg;
		end
	end

	// Change flag, suppressed under autoflow; set wins over read clear
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			delta_cts_reg <= 1'b0;
		end else if (cts_sync_reg != cts_prev_reg && !auto_cts) begin
			delta_cts_reg <= 1'b1;
		end else if (i_read && i_addr == `UAF_ADDR_MODEM_STAT) begin
			delta_cts_reg <= 1'b0;
		end
	end

	// ****************************************
	// FIFOs
	// ****************************************
	assign tx_push = i_write && i_addr == `UAF_ADDR_DATA;
	assign rx_pop = i_read && i_addr == `UAF_ADDR_DATA && rx_valid;

	uaf_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_clear(tx_clear),
		.i_limit(limit),
		.i_push_valid(tx_push),
		.i_push_data(i_wdata),
		.o_push_ready(tx_ready),
		.i_pop(tx_pop),
		.o_pop_valid(tx_valid),
		.o_pop_data(tx_head),
		.o_count(tx_count)
	);

	uaf_fifo #(.W(11), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_clear(rx_clear),
		.i_limit(limit),
		.i_push_valid(rx_push),
		.i_push_data(rx_entry),
		.o_push_ready(rx_ready),
		.i_pop(rx_pop),
		.o_pop_valid(rx_valid),
		.o_pop_data(rx_head),
		.o_count(rx_count)
	);

	// DMA request levels
	assign o_transmit_dma_request = fifo_en ? (tx_count == '0) : !tx_valid;
	assign o_receive_dma_request = fifo_en ? (rx_count >= trig_val) : rx_valid;

	// ****************************************
	// Transmitter
	// ****************************************
	assign tx_bit_end = tick && tx_tick_reg == `UAF_TICK_LAST;
	// CTS checked before each byte only; without auto-CTS it is ignored
	assign tx_load = tx_valid && (!auto_cts || cts_active);
	assign tx_pop = tx_load && (tx_state_reg == uaf_pkg::tx_idle
		|| (tx_state_reg == uaf_pkg::tx_stop && tx_bit_end));
	assign o_serial_output = tx_out_reg;

	// Frame sequencer
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_state_reg <= uaf_pkg::tx_idle;
			tx_tick_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_par_reg <= 1'b0;
		end else begin
			if (tick) begin
				tx_tick_reg <= tx_tick_reg + 4'h1;
			end
			case (tx_state_reg)
				uaf_pkg::tx_idle: begin
					tx_tick_reg <= 4'h0;
					if (tx_pop) begin
						tx_state_reg <= uaf_pkg::tx_start;
					end
				end
				uaf_pkg::tx_start: begin
					if (tx_bit_end) begin
						tx_state_reg <= uaf_pkg::tx_data;
						tx_bit_reg <= 3'h0;
					end
				end
				uaf_pkg::tx_data: begin
					if (tx_bit_end) begin
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						tx_par_reg <= tx_par_reg ^ tx_shift_reg[0];
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg == last_bit) begin
							tx_state_reg <= lcr_reg[`UAF_LCR_PAR_EN] ? uaf_pkg::tx_par
								: uaf_pkg::tx_stop;
						end
					end
				end
				uaf_pkg::tx_par: begin
					if (tx_bit_end) begin
						tx_state_reg <= uaf_pkg::tx_stop;
					end
				end
				uaf_pkg::tx_stop: begin
					// Byte in progress always completes its stop bit
					if (tx_bit_end) begin
						tx_state_reg <= tx_pop ? uaf_pkg::tx_start : uaf_pkg::tx_idle;
					end
				end
				default: tx_state_reg <= uaf_pkg::tx_idle;
			endcase
			if (tx_pop) begin
				tx_shift_reg <= tx_head;
				tx_par_reg <= !lcr_reg[`UAF_LCR_PAR_EVEN];
			end
		end
	end

	// Line driver
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_out_reg <= 1'b1;
		end else begin
			case (tx_state_reg)
				uaf_pkg::tx_start: tx_out_reg <= 1'b0;
				uaf_pkg::tx_data: tx_out_reg <= tx_shift_reg[0];
				uaf_pkg::tx_par: tx_out_reg <= tx_par_reg;
				default: tx_out_reg <= 1'b1;
			endcase
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	assign rx_mid = tick && rx_tick_reg == `UAF_TICK_LAST;
	assign rx_first_bit = rx_state_reg == uaf_pkg::rx_data && rx_mid && rx_bit_reg == 3'h0;
	assign rx_push = rx_state_reg == uaf_pkg::rx_stop && rx_mid;
	assign rx_entry = '{brk: rx_shift_reg == 8'h00 && !sin_sync_reg,
		frame: !sin_sync_reg, par: rx_perr_reg, data: rx_shift_reg};

	// Frame sampler with false-start rejection
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_state_reg <= uaf_pkg::rx_idle;
			rx_tick_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_par_reg <= 1'b0;
			rx_perr_reg <= 1'b0;
		end else begin
			if (tick) begin
				rx_tick_reg <= rx_tick_reg + 4'h1;
			end
			case (rx_state_reg)
				uaf_pkg::rx_idle: begin
					rx_tick_reg <= 4'h0;
					if (!sin_sync_reg) begin
						rx_state_reg <= uaf_pkg::rx_start;
					end
				end
				uaf_pkg::rx_start: begin
					if (tick && rx_tick_reg == `UAF_TICK_HALF) begin
						rx_tick_reg <= 4'h0;
						rx_bit_reg <= 3'h0;
						rx_shift_reg <= 8'h00;
						rx_perr_reg <= 1'b0;
						rx_par_reg <= !lcr_reg[`UAF_LCR_PAR_EVEN];
						rx_state_reg <= sin_sync_reg ? uaf_pkg::rx_idle : uaf_pkg::rx_data;
					end
				end
				uaf_pkg::rx_data: begin
					if (rx_mid) begin
						rx_shift_reg[rx_bit_reg] <= sin_sync_reg;
						rx_par_reg <= rx_par_reg ^ sin_sync_reg;
						rx_bit_reg <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == last_bit) begin
							rx_state_reg <= lcr_reg[`UAF_LCR_PAR_EN] ? uaf_pkg::rx_par
								: uaf_pkg::rx_stop;
						end
					end
				end
				uaf_pkg::rx_par: begin
					if (rx_mid) begin
						rx_perr_reg <= rx_par_reg ^ sin_sync_reg;
						rx_state_reg <= uaf_pkg::rx_stop;
					end
				end
				uaf_pkg::rx_stop: begin
					if (rx_mid) begin
						rx_state_reg <= uaf_pkg::rx_idle;
					end
				end
				default: rx_state_reg <= uaf_pkg::rx_idle;
			endcase
		end
	end

	// Overrun flag; set wins over the status read
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			overrun_reg <= 1'b0;
		end else if (rx_push && !rx_ready) begin
			overrun_reg <= 1'b1;
		end else if (i_read && i_addr == `UAF_ADDR_LINE_STAT) begin
			overrun_reg <= 1'b0;
		end
	end

	// ****************************************
	// Automatic RTS
	// ****************************************
	// Levels 1/4/8: latch release at trigger, drop it only when empty
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			hold_reg <= 1'b0;
		end else if (rx_clear) begin
			hold_reg <= 1'b0;
		end else if (rx_count >= trig_val) begin
			hold_reg <= 1'b1;
		end else if (rx_count == '0) begin
			hold_reg <= 1'b0;
		end
	end

	// Level 14: release at first data bit of the byte that would fill
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			block14_reg <= 1'b0;
		end else if (rx_clear) begin
			block14_reg <= 1'b0;
		end else if (rx_first_bit && rx_count == CW'(DEPTH - 1) && !rx_pop) begin
			block14_reg <= 1'b1;
		end else if (rx_pop) begin
			block14_reg <= 1'b0;
		end else if (rx_count == CW'(DEPTH)) begin
			block14_reg <= 1'b1;
		end
	end

	assign rts_release = auto_rts && (lvl14 ? block14_reg : hold_reg);
	assign o_rts_n = !(mcr_reg[`UAF_MCR_RTS] && !rts_release);

	// ****************************************
	// Read port
	// ****************************************
	assign o_rdata = rdata_reg;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_reg <= 8'h00;
		end else if (i_read) begin
			case (i_addr)
				`UAF_ADDR_DATA: rdata_reg <= rx_valid ? rx_head.data : 8'h00;
				`UAF_ADDR_LINE_CTRL: rdata_reg <= lcr_reg;
				`UAF_ADDR_FIFO_CTRL: rdata_reg <= fcr_reg;
				`UAF_ADDR_MODEM_CTRL: rdata_reg <= mcr_reg;
				`UAF_ADDR_LINE_STAT: rdata_reg <= {1'b0, !tx_valid && tx_state_reg == uaf_pkg::tx_idle,
					!tx_valid, rx_valid && rx_head.brk, rx_valid && rx_head.frame,
					rx_valid && rx_head.par, overrun_reg, rx_valid};
				`UAF_ADDR_MODEM_STAT: rdata_reg <= {3'h0, cts_active, 3'h0, delta_cts_reg};
				`UAF_ADDR_DIV_LO: rdata_reg <= div_reg[7:0];
				default: rdata_reg <= div_reg[15:8];
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_cts_gate;
		@(posedge i_clock) disable iff (!i_resetn)
		$rose(tx_state_reg == uaf_pkg::tx_start) |-> $past(!auto_cts || cts_active);
	endproperty
	a_cts_gate: assert property (p_cts_gate) else $error("byte started with CTS inactive");

	property p_rts_trig;
		@(posedge i_clock) disable iff (!i_resetn)
		(auto_rts && !lvl14 && rx_count >= trig_val && !i_write) |=> o_rts_n;
	endproperty
	a_rts_trig: assert property (p_rts_trig) else $error("RTS kept at trigger level");

	property p_rts_hold;
		@(posedge i_clock) disable iff (!i_resetn)
		(auto_rts && !lvl14 && o_rts_n && rx_count != '0 && !i_write) |=> o_rts_n;
	endproperty
	a_rts_hold: assert property (p_rts_hold) else $error("RTS returned before empty");

	property p_rts_empty;
		@(posedge i_clock) disable iff (!i_resetn)
		(auto_rts && !lvl14 && rx_count == '0 && !i_write) |=> !o_rts_n;
	endproperty
	a_rts_empty: assert property (p_rts_empty) else $error("RTS not returned on empty");

	property p_rts14_stop;
		@(posedge i_clock) disable iff (!i_resetn)
		(auto_rts && lvl14 && rx_first_bit && rx_count == CW'(DEPTH - 1) && !rx_pop
			&& !i_write) |=> o_rts_n;
	endproperty
	a_rts14_stop: assert property (p_rts14_stop) else $error("RTS kept at 16th byte");

	property p_rts14_room;
		@(posedge i_clock) disable iff (!i_resetn)
		(auto_rts && lvl14 && rx_count < CW'(DEPTH - 1)) |-> !o_rts_n;
	endproperty
	a_rts14_room: assert property (p_rts14_room) else $error("RTS released with room");

	property p_rts14_full_read;
		@(posedge i_clock) disable iff (!i_resetn)
		(auto_rts && lvl14 && rx_count == CW'(DEPTH) && rx_pop && !i_write) |=> !o_rts_n;
	endproperty
	a_rts14_full_read: assert property (p_rts14_full_read) else $error("full read kept RTS");

	property p_stop_hold;
		@(posedge i_clock) disable iff (!i_resetn)
		(tx_state_reg == uaf_pkg::tx_stop && tx_bit_end && auto_cts && !cts_active)
			|=> tx_state_reg == uaf_pkg::tx_idle;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("next byte sent with CTS off");

	property p_back_to_back;
		@(posedge i_clock) disable iff (!i_resetn)
		(tx_state_reg == uaf_pkg::tx_stop && tx_bit_end && tx_valid && (!auto_cts || cts_active))
			|=> tx_state_reg == uaf_pkg::tx_start ##1 !o_serial_output;
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("gap between bytes");

	property p_no_delta;
		@(posedge i_clock) disable iff (!i_resetn)
		(auto_cts && !delta_cts_reg && !i_write) |=> !delta_cts_reg;
	endproperty
	a_no_delta: assert property (p_no_delta) else $error("CTS change flagged under autoflow");

	property p_rts_manual;
		@(posedge i_clock) disable iff (!i_resetn)
		!mcr_reg[`UAF_MCR_AFE] |-> o_rts_n == !mcr_reg[`UAF_MCR_RTS];
	endproperty
	a_rts_manual: assert property (p_rts_manual) else $error("RTS not following bit");
endmodule

// File: src/uaf_map.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 8-bit register port with 3-bit address
// Notes: definitions only
`ifndef UAF_MAP_SVH
`define UAF_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define UAF_ADDR_DATA 3'h0
`define UAF_ADDR_LINE_CTRL 3'h1
`define UAF_ADDR_FIFO_CTRL 3'h2
`define UAF_ADDR_MODEM_CTRL 3'h3
`define UAF_ADDR_LINE_STAT 3'h4
`define UAF_ADDR_MODEM_STAT 3'h5
`define UAF_ADDR_DIV_LO 3'h6
`define UAF_ADDR_DIV_HI 3'h7
// ****************************************
// Field positions
// ****************************************
`define UAF_LCR_PAR_EN 3
`define UAF_LCR_PAR_EVEN 4
`define UAF_FCR_EN 0
`define UAF_FCR_RX_CLR 1
`define UAF_FCR_TX_CLR 2
`define UAF_MCR_RTS 1
`define UAF_MCR_AFE 5
// ****************************************
// Reset values and counts
// ****************************************
`define UAF_LCR_RST 8'h03
`define UAF_FCR_RST 8'h00
`define UAF_MCR_RST 8'h00
`define UAF_DIV_RST 16'h0001
`define UAF_FCR_KEEP 8'hc1
`define UAF_FIFO_DEPTH 16
`define UAF_TICK_LAST 4'hf
`define UAF_TICK_HALF 4'h7
`define UAF_DATA_BIT_BASE 3'h4
`define UAF_TRIG_1 5'h01
`define UAF_TRIG_4 5'h04
`define UAF_TRIG_8 5'h08
`define UAF_TRIG_14 5'h0e
`endif

// File: src/uaf_pkg.sv
// Purpose: shared types of the autoflow serial element
// Assumes: nothing
// Notes: constants live in uaf_map.svh
package uaf_pkg;
	// Receive FIFO entry: three error bits beside the byte
	typedef struct packed {
		logic brk;
		logic frame;
		logic par;
		logic [7:0] data;
	} uaf_rx_entry_s;

	typedef enum logic [2:0] {
		tx_idle,
		tx_start,
		tx_data,
		tx_par,
		tx_stop
	} uaf_tx_state_e;

	typedef enum logic [2:0] {
		rx_idle,
		rx_start,
		rx_data,
		rx_par,
		rx_stop
	} uaf_rx_state_e;
endpackage

// File: src/uaf_fifo.sv
// Purpose: flop-based FIFO with a run-time fill limit
// Assumes: DEPTH is a power of two
// Notes: a limit of 1 gives single-character holding behaviour
`timescale 1ns/1ps
module uaf_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	parameter int CW = $clog2(DEPTH) + 1
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_clear,
	input wire logic [CW-1:0] i_limit,
	input wire logic i_push_valid,
	input wire logic [W-1:0] i_push_data,
	output logic o_push_ready,
	input wire logic i_pop,
	output logic o_pop_valid,
	output logic [W-1:0] o_pop_data,
	output logic [CW-1:0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic do_push;
	logic do_pop;

	// Handshake terms
	assign o_push_ready = count_reg < i_limit;
	assign o_pop_valid = count_reg != '0;
	assign do_push = i_push_valid && o_push_ready;
	assign do_pop = i_pop && o_pop_valid;
	assign o_pop_data = mem_reg[rd_ptr_reg];
	assign o_count = count_reg;

	// Storage
	always_ff @(posedge i_clock) begin
		if (do_push) begin
			mem_reg[wr_ptr_reg] <= i_push_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (i_clear) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (do_pop) begin
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			end
			count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule

// File: dv/uaf_remote.sv
// Purpose: remote serial party beside the flow-controlled element
// Assumes: 8N1 framing, divisor 1, so 16 clocks a bit
// Notes: waits for request-to-send only before a new byte
`timescale 1ns/1ps
module uaf_remote (
	input wire logic i_clock,
	input wire logic i_line,
	input wire logic i_rts_n,
	output logic o_line
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	// Line idles high between frames
	initial o_line = 1'b1;
	// ****************************************
	// Sender and receiver
	// ****************************************
	// Send one frame once request-to-send is active
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(posedge i_clock);
		while (i_rts_n) @(posedge i_clock);
		for (int i = 0; i < 10; i++) begin
			o_line <= f[i];
			repeat (16) @(posedge i_clock);
		end
	endtask
	// Collect bytes from the element, sampled mid-bit
	always begin
		@(negedge i_line);
		repeat (8) @(posedge i_clock);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge i_clock);
			sh[i] = i_line;
		end
		repeat (16) @(posedge i_clock);
		rx_q.push_back(sh);
	end
endmodule

// File: dv/uart_autoflow_control_bench.sv
// Purpose: register-level tests of automatic RTS/CTS flow
// Assumes: divisor 1 and 8N1 frames, except the 7-bit and divisor-2 tests
// Notes: remote party model sits on the serial pins
`timescale 1ns/1ps
module uart_autoflow_control_bench;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_write = 1'b0;
	logic i_read = 1'b0;
	logic i_cts_n = 1'b1;
	logic [7:0] o_rdata;
	logic [7:0] v;
	logic o_serial_output, o_rts_n, o_baud_clock_out, o_tdr, o_rdr, line_in;
	int n_errors = 0;
	int samples_checked = 0;
	int lv[3] = '{1, 4, 8};
	// 40 MHz clock
	always #12.5 i_clock = ~i_clock;
	uaf_top u_uaf_top (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_write(i_write),
		.i_read(i_read),
		.o_rdata(o_rdata),
		.i_serial_input_line(line_in),
		.o_serial_output(o_serial_output),
		.i_cts_n(i_cts_n),
		.o_rts_n(o_rts_n),
		.o_baud_clock_out(o_baud_clock_out),
		.o_transmit_dma_request(o_tdr),
		.o_receive_dma_request(o_rdr)
	);
	uaf_remote u_uaf_remote (
		.i_clock(i_clock),
		.i_line(o_serial_output),
		.i_rts_n(o_rts_n),
		.o_line(line_in)
	);
	// ****************************************
	// Access and check tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_write <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_clock);
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic cts(input logic b);
		@(posedge i_clock);
		i_cts_n <= b;
	endtask
	// Count of bytes seen by the remote and the latest one
	task automatic qchk(input logic [7:0] n, input logic [7:0] b);
		chk(8'(u_uaf_remote.rx_q.size()), n);
		if (u_uaf_remote.rx_q.size() > 0)
			chk(u_uaf_remote.rx_q[$], b);
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog, far beyond the expected run
	initial begin
		repeat (40000) @(posedge i_clock);
		n_errors++;
		wrap_up();
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge i_clock);
		i_resetn <= 1'b1;
		rd(3'h1, v);
		chk(v, 8'h03);
		rd(3'h2, v);
		chk(v, 8'h00);
		chk({7'h00, o_rts_n}, 8'h01);
		chk({7'h00, o_baud_clock_out}, 8'h01);
		chk({7'h00, o_tdr}, 8'h01);
		wr(3'h3, 8'h02);
		wt(2);
		chk({7'h00, o_rts_n}, 8'h00);
		// Character mode ignores CTS even with autoflow set
		wr(3'h3, 8'h20);
		wr(3'h0, 8'ha5);
		wt(200);
		qchk(8'h01, 8'ha5);
		// FIFO mode without autoflow ignores CTS
		wr(3'h2, 8'h01);
		wr(3'h3, 8'h00);
		wr(3'h0, 8'h5a);
		wt(200);
		qchk(8'h02, 8'h5a);
		// Auto-CTS only: bytes held while CTS inactive
		wr(3'h3, 8'h20);
		wr(3'h0, 8'h3c);
		wr(3'h0, 8'hc3);
		wt(400);
		chk({7'h00, o_rts_n}, 8'h01);
		qchk(8'h02, 8'h5a);
		chk({7'h00, o_tdr}, 8'h00);
		cts(1'b0);
		wt(40);
		cts(1'b1);
		wt(400);
		qchk(8'h03, 8'h3c);
		rd(3'h5, v);
		chk(v & 8'h01, 8'h00);
		cts(1'b0);
		wt(200);
		qchk(8'h04, 8'hc3);
		// Two queued bytes leave with no gap
		wr(3'h0, 8'h11);
		wr(3'h0, 8'h22);
		wt(322);
		qchk(8'h06, 8'h22);
		// Seven data bits: remote sees the stop bit as its top bit
		wr(3'h1, 8'h02);
		wr(3'h0, 8'h55);
		wt(200);
		qchk(8'h07, 8'hd5);
		wr(3'h1, 8'h03);
		// Auto-RTS at trigger levels 1, 4 and 8
		wr(3'h3, 8'h22);
		foreach (lv[k]) begin
			wr(3'h2, {k[1:0], 6'h01});
			wt(2);
			for (int j = 0; j < lv[k]; j++) begin
				chk({7'h00, o_rts_n}, 8'h00);
				u_uaf_remote.send(8'h40 + j[7:0]);
			end
			wt(4);
			chk({7'h00, o_rts_n}, 8'h01);
			chk({7'h00, o_rdr}, 8'h01);
			for (int j = 0; j < lv[k]; j++) begin
				rd(3'h0, v);
				chk(v, 8'h40 + j[7:0]);
				if (j < lv[k] - 1)
					chk({7'h00, o_rts_n}, 8'h01);
			end
			wt(2);
			chk({7'h00, o_rts_n}, 8'h00);
			chk({7'h00, o_rdr}, 8'h00);
		end
		// Level 14: full FIFO, first read brings RTS back
		wr(3'h2, 8'hc1);
		for (int j = 0; j < 16; j++)
			u_uaf_remote.send(8'h80 + j[7:0]);
		wt(4);
		chk({7'h00, o_rts_n}, 8'h01);
		rd(3'h0, v);
		chk(v, 8'h80);
		wt(2);
		chk({7'h00, o_rts_n}, 8'h00);
		// Byte in flight at release is kept in order
		for (int j = 1; j < 16; j++) begin
			rd(3'h0, v);
			chk(v, 8'h80 + j[7:0]);
		end
		// Divisor 2: the 16x pin alternates each cycle
		wr(3'h6, 8'h02);
		wt(3);
		v[0] = o_baud_clock_out;
		wt(1);
		chk({7'h00, v[0] ^ o_baud_clock_out}, 8'h01);
		wrap_up();
	end
endmodule
